//--- core/cict_regs.svh
// Operation
// - count execution in single system clocks only
// - most instructions: clocks equal program bytes
// - untaken conditional branch is one clock shorter
// - add/addc/subb with bank register: 1 byte, 1 clock
// - accumulator op via indirect pointer: 1 byte, 2 clocks
// - inc/dec via indirect pointer: 1 byte, 2 clocks
// - logic immediate into direct byte: 3 bytes, 3 clocks
// - logic immediate into accumulator: 2 bytes, 2 clocks
// - direct to direct move: 3 bytes, 3 clocks
// - code byte read: 1 byte, 3 clocks
// - external move via 8-bit pointer: 1 byte, 3 clocks
// - external move via data pointer: 1 byte, 3 clocks
// - load data pointer immediate: 3 bytes, 3 clocks
// - increment data pointer: 1 byte, 1 clock
// - push or pop direct: 2 bytes, 2 clocks
// - store accumulator indirect: 1 byte, 2 clocks
// - immediate into indirect RAM: 2 bytes, 2 clocks
// - exchange or nibble exchange indirect: 1 byte, 2 clocks
// - rotates and nibble swap: 1 byte, 1 clock
// - clear/set/complement direct bit: 2 bytes, 2 clocks
// - branch target is next address plus signed offset
// - spare opcode behaves exactly like no-operation
`ifndef CICT_REGS_SVH
`define CICT_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CICT_CLK_PERIOD_NS 5

// ----------------------------------------------------------------
// instruction lengths and clock counts
// ----------------------------------------------------------------
`define CICT_B1 2'h1
`define CICT_B2 2'h2
`define CICT_B3 2'h3
`define CICT_C1 4'h1
`define CICT_C2 4'h2
`define CICT_C3 4'h3
`define CICT_C4 4'h4
`define CICT_C5 4'h5
`define CICT_C8 4'h8

// ----------------------------------------------------------------
// special opcodes
// ----------------------------------------------------------------
`define CICT_OP_NOP 8'h00
`define CICT_OP_SPARE 8'ha5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CICT_RST_LEN 2'h0
`define CICT_RST_CLK 4'h0
`define CICT_RST_PC 16'h0000
`define CICT_RST_CNT 16'h0000

`endif

//--- core/cict_pkg.sv
package cict_pkg;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_exec = 2'b10
  } cict_state_e;

  typedef struct packed {
    logic [1:0] len;
    logic [3:0] clk_taken;
    logic cond;
    logic nop_like;
  } cict_dec_s;

endpackage

//--- core/cict_dec_if.sv
`timescale 1ns/1ps
interface cict_dec_if;
  import cict_pkg::*;
  logic [7:0] opcode;
  cict_dec_s dec;
  modport dec_side (input opcode, output dec);
  modport core_side (output opcode, input dec);
endinterface

//--- core/cict_decoder.sv
`timescale 1ns/1ps
`include "cict_regs.svh"
module cict_decoder import cict_pkg::*; (
  cict_dec_if.dec_side bus
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic cict_dec_s cict_mk(input logic [1:0] len,
                                        input logic [3:0] clk,
                                        input logic cond);
    cict_dec_s d;
    d.len = len;
    d.clk_taken = clk;
    d.cond = cond;
    d.nop_like = 1'b0;
    return d;
  endfunction

  // clk_taken is the taken-branch figure; the core derives the short one
  function automatic cict_dec_s cict_decode_op(input logic [7:0] op);
    cict_dec_s d;
    logic [3:0] r;
    r = op[7:4];
    d = cict_mk(`CICT_B1, `CICT_C1, 1'b0);
    if (op[3]) begin
      case (r)
        4'h7, 4'h8, 4'ha: d = cict_mk(`CICT_B2, `CICT_C2, 1'b0);
        4'hb: d = cict_mk(`CICT_B3, `CICT_C4, 1'b1);
        4'hd: d = cict_mk(`CICT_B2, `CICT_C3, 1'b1);
        default: d = cict_mk(`CICT_B1, `CICT_C1, 1'b0);
      endcase
    end else begin
      case (op[2:0])
        3'h6, 3'h7: begin
          case (r)
            4'h7: d = cict_mk(`CICT_B2, `CICT_C2, 1'b0);
            4'h8, 4'ha: d = cict_mk(`CICT_B2, `CICT_C2, 1'b0);
            4'hb: d = cict_mk(`CICT_B3, `CICT_C5, 1'b1);
            default: d = cict_mk(`CICT_B1, `CICT_C2, 1'b0);
          endcase
        end
        3'h5: begin
          case (r)
            4'h7, 4'h8: d = cict_mk(`CICT_B3, `CICT_C3, 1'b0);
            4'hb, 4'hd: d = cict_mk(`CICT_B3, `CICT_C4, 1'b1);
            4'ha: d = cict_mk(`CICT_B1, `CICT_C1, 1'b0);
            default: d = cict_mk(`CICT_B2, `CICT_C2, 1'b0);
          endcase
        end
        3'h4: begin
          case (r)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin
              d = cict_mk(`CICT_B2, `CICT_C2, 1'b0);
            end
            4'h8: d = cict_mk(`CICT_B1, `CICT_C8, 1'b0);
            4'ha: d = cict_mk(`CICT_B1, `CICT_C4, 1'b0);
            4'hb: d = cict_mk(`CICT_B3, `CICT_C4, 1'b1);
            default: d = cict_mk(`CICT_B1, `CICT_C1, 1'b0);
          endcase
        end
        3'h1: d = cict_mk(`CICT_B2, `CICT_C3, 1'b0);
        3'h0: begin
          case (r)
            4'h0: d = cict_mk(`CICT_B1, `CICT_C1, 1'b0);
            4'h1, 4'h2, 4'h3: d = cict_mk(`CICT_B3, `CICT_C4, 1'b1);
            4'h4, 4'h5, 4'h6, 4'h7: d = cict_mk(`CICT_B2, `CICT_C3, 1'b1);
            4'h8: d = cict_mk(`CICT_B2, `CICT_C3, 1'b0);
            4'h9: d = cict_mk(`CICT_B3, `CICT_C3, 1'b0);
            4'he, 4'hf: d = cict_mk(`CICT_B1, `CICT_C3, 1'b0);
            default: d = cict_mk(`CICT_B2, `CICT_C2, 1'b0);
          endcase
        end
        3'h2: begin
          case (r)
            4'h0, 4'h1: d = cict_mk(`CICT_B3, `CICT_C4, 1'b0);
            4'h2, 4'h3: d = cict_mk(`CICT_B1, `CICT_C5, 1'b0);
            4'he, 4'hf: d = cict_mk(`CICT_B1, `CICT_C3, 1'b0);
            default: d = cict_mk(`CICT_B2, `CICT_C2, 1'b0);
          endcase
        end
        default: begin
          case (r)
            4'h4, 4'h5, 4'h6: d = cict_mk(`CICT_B3, `CICT_C3, 1'b0);
            4'h7, 4'h8, 4'h9: begin
              d = cict_mk(`CICT_B1, `CICT_C3, 1'b0);
            end
            4'he, 4'hf: d = cict_mk(`CICT_B1, `CICT_C3, 1'b0);
            default: d = cict_mk(`CICT_B1, `CICT_C1, 1'b0);
          endcase
        end
      endcase
    end
    // the spare code is flagged like NOP; the flag only feeds nop_equiv, not execute
    d.nop_like = (op == `CICT_OP_NOP) || (op == `CICT_OP_SPARE);
    return d;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign bus.dec = cict_decode_op(bus.opcode);

endmodule

//--- core/cict_core.sv
`timescale 1ns/1ps
`include "cict_regs.svh"
module cict_core import cict_pkg::*; (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic cond_true,
  input wire logic [7:0] rel_disp,
  input wire logic [15:0] next_pc,
  output logic op_ready,
  output logic busy,
  output logic exec_done,
  output logic [1:0] instr_len,
  output logic [3:0] instr_clocks,
  output logic cond_branch,
  output logic branch_taken,
  output logic nop_equiv,
  output logic [15:0] branch_target,
  output logic [15:0] clock_count
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  cict_dec_if dec_bus ();
  cict_dec_s dec;
  logic accept;
  logic [3:0] eff_clocks;

  assign dec_bus.opcode = op_code;
  assign dec = dec_bus.dec;
  assign accept = op_valid && op_ready;

  cict_decoder u_dec (
    .bus(dec_bus)
  );

  always_comb begin
    eff_clocks = dec.clk_taken;
    if (dec.cond && !cond_true) begin
      eff_clocks = dec.clk_taken - `CICT_C1;
    end
  end

  // ----------------------------------------------------------------
  // execute sequencer
  // ----------------------------------------------------------------
  cict_state_e state;
  cict_state_e next_state;
  logic [3:0] remaining;
  logic [3:0] next_remaining;

  // one state step per core clock, no machine-cycle grouping
  always_comb begin
    next_state = state;
    next_remaining = remaining;
    case (state)
      st_idle: begin
        if (accept) begin
          next_state = st_exec;
          next_remaining = eff_clocks - `CICT_C1;
        end
      end
      st_exec: begin
        if (remaining != `CICT_RST_CLK) begin
          next_remaining = remaining - `CICT_C1;
        end else if (accept) begin
          next_remaining = eff_clocks - `CICT_C1;
        end else begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
        next_remaining = `CICT_RST_CLK;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= st_idle;
      remaining <= `CICT_RST_CLK;
    end else begin
      state <= next_state;
      remaining <= next_remaining;
    end
  end

  // ready is registered, so the next opcode is taken in the last
  // execute cycle and back-to-back instructions lose no clock
  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      op_ready <= 1'b0;
      busy <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      op_ready <= (next_state == st_idle) ||
                  (next_remaining == `CICT_RST_CLK);
      busy <= (next_state == st_exec);
      exec_done <= (next_state == st_exec) &&
                   (next_remaining == `CICT_RST_CLK);
    end
  end

  // ----------------------------------------------------------------
  // per-instruction results
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      instr_len <= `CICT_RST_LEN;
      instr_clocks <= `CICT_RST_CLK;
      cond_branch <= 1'b0;
      branch_taken <= 1'b0;
      nop_equiv <= 1'b0;
    end else if (accept) begin
      instr_len <= dec.len;
      instr_clocks <= eff_clocks;
      cond_branch <= dec.cond;
      branch_taken <= dec.cond && cond_true;
      nop_equiv <= dec.nop_like;
    end
  end

  // offset is relative to the first byte of the following instruction
  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      branch_target <= `CICT_RST_PC;
    end else if (accept) begin
      branch_target <= next_pc + {{8{rel_disp[7]}}, rel_disp};
    end
  end

  // free-running count of execute clocks; wraps silently
  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      clock_count <= `CICT_RST_CNT;
    end else if (busy) begin
      clock_count <= clock_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] run_cnt;

  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      run_cnt <= `CICT_RST_CLK;
    end else if (accept) begin
      run_cnt <= `CICT_RST_CLK;
    end else if (busy) begin
      run_cnt <= run_cnt + `CICT_C1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync);

  property p_r1;
    busy |=> clock_count == $past(clock_count) + 16'h0001;
  endproperty
  a_r1: assert property (p_r1) else $error("clock count skipped");

  property p_r2;
    exec_done |-> run_cnt == instr_clocks - `CICT_C1;
  endproperty
  a_r2: assert property (p_r2) else $error("run length wrong");

  property p_r3;
    accept && dec.cond && !cond_true |=>
      instr_clocks == $past(dec.clk_taken) - `CICT_C1 && !branch_taken;
  endproperty
  a_r3: assert property (p_r3) else $error("skip not shorter");

  property p_r4;
    accept && (op_code inside {[8'h28:8'h2f], [8'h38:8'h3f],
                               [8'h98:8'h9f]}) |=>
      instr_len == `CICT_B1 && instr_clocks == `CICT_C1 && exec_done;
  endproperty
  a_r4: assert property (p_r4) else $error("bank add timing");

  property p_r5;
    accept && op_code[3:1] == 3'h3 &&
      (op_code[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9}) |=>
      instr_len == `CICT_B1 && !exec_done ##1 exec_done;
  endproperty
  a_r5: assert property (p_r5) else $error("indirect alu timing");

  property p_r6;
    accept && (op_code inside {8'h06, 8'h07, 8'h16, 8'h17}) |=>
      instr_len == `CICT_B1 && instr_clocks == `CICT_C2;
  endproperty
  a_r6: assert property (p_r6) else $error("indirect inc timing");

  property p_r7;
    accept && (op_code inside {8'h43, 8'h53, 8'h63}) |=>
      instr_len == `CICT_B3 && instr_clocks == `CICT_C3;
  endproperty
  a_r7: assert property (p_r7) else $error("logic direct timing");

  property p_r8;
    accept && (op_code inside {8'h44, 8'h54, 8'h64}) |=>
      instr_len == `CICT_B2 && instr_clocks == `CICT_C2;
  endproperty
  a_r8: assert property (p_r8) else $error("logic acc timing");

  property p_r9;
    accept && op_code == 8'h85 |=>
      instr_len == `CICT_B3 && !exec_done [*2] ##1 exec_done;
  endproperty
  a_r9: assert property (p_r9) else $error("direct move timing");

  property p_r10;
    accept && (op_code inside {8'h83, 8'h93}) |=>
      instr_len == `CICT_B1 && instr_clocks == `CICT_C3;
  endproperty
  a_r10: assert property (p_r10) else $error("code read timing");

  property p_r11;
    accept && (op_code inside {8'he2, 8'he3, 8'hf2, 8'hf3}) |=>
      instr_len == `CICT_B1 && busy [*3];
  endproperty
  a_r11: assert property (p_r11) else $error("ext 8-bit timing");

  property p_r12;
    accept && (op_code inside {8'he0, 8'hf0}) |=>
      instr_len == `CICT_B1 && instr_clocks == `CICT_C3;
  endproperty
  a_r12: assert property (p_r12) else $error("ext 16-bit timing");

  property p_r13;
    accept && op_code == 8'h90 |=>
      instr_len == `CICT_B3 && instr_clocks == `CICT_C3;
  endproperty
  a_r13: assert property (p_r13) else $error("pointer load timing");

  property p_r14;
    accept && op_code == 8'ha3 |=>
      instr_len == `CICT_B1 && exec_done && op_ready;
  endproperty
  a_r14: assert property (p_r14) else $error("pointer inc timing");

  property p_r15;
    accept && (op_code inside {8'hc0, 8'hd0}) |=>
      instr_len == `CICT_B2 && instr_clocks == `CICT_C2;
  endproperty
  a_r15: assert property (p_r15) else $error("push pop timing");

  property p_r16;
    accept && (op_code inside {8'hf6, 8'hf7}) |=>
      instr_len == `CICT_B1 && instr_clocks == `CICT_C2;
  endproperty
  a_r16: assert property (p_r16) else $error("store ind timing");

  property p_r17;
    accept && (op_code inside {8'h76, 8'h77}) |=>
      instr_len == `CICT_B2 && instr_clocks == `CICT_C2;
  endproperty
  a_r17: assert property (p_r17) else $error("imm ind timing");

  property p_r18;
    accept && (op_code inside {8'hc6, 8'hc7, 8'hd6, 8'hd7}) |=>
      instr_len == `CICT_B1 && instr_clocks == `CICT_C2;
  endproperty
  a_r18: assert property (p_r18) else $error("exchange timing");

  property p_r19;
    accept && (op_code inside {8'h03, 8'h13, 8'h23, 8'h33, 8'hc4}) |=>
      instr_len == `CICT_B1 && instr_clocks == `CICT_C1;
  endproperty
  a_r19: assert property (p_r19) else $error("rotate timing");

  property p_r20;
    accept && (op_code inside {8'hb2, 8'hc2, 8'hd2}) |=>
      instr_len == `CICT_B2 && instr_clocks == `CICT_C2;
  endproperty
  a_r20: assert property (p_r20) else $error("bit op timing");

  property p_r21;
    accept |=> branch_target ==
      $past(next_pc) + {{8{$past(rel_disp[7])}}, $past(rel_disp)};
  endproperty
  a_r21: assert property (p_r21) else $error("branch target");

  property p_r22;
    accept && op_code == `CICT_OP_SPARE |=>
      nop_equiv && instr_len == `CICT_B1 && instr_clocks == `CICT_C1;
  endproperty
  a_r22: assert property (p_r22) else $error("spare not nop");

  c_skip: cover property (accept && dec.cond && !cond_true);
  c_taken: cover property (accept && dec.cond && cond_true);
  c_b2b: cover property (exec_done && accept ##1 exec_done);
  c_div: cover property (accept && op_code == 8'h84 ##8 exec_done);

endmodule

//--- tb/cict_prog_mem.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// program memory that feeds the opcode port
// ----------------------------------------------------------------
module cict_prog_mem (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem [256];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  // combinational read: the offered byte stays put while addr is held
  assign rd_data = mem[addr];
endmodule

//--- tb/cict_core_bench.sv
`timescale 1ns/1ps
`include "cict_regs.svh"

`define CICT_CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("BAD %0t got %0h exp %0h", $time, got, exp); \
  end \
end

module cict_core_bench import cict_pkg::*;;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0;
  logic cond_true = 1'b0;
  logic [7:0] rel_disp = 8'h00;
  logic [15:0] next_pc = 16'h0000;
  logic pm_we = 1'b0;
  logic [7:0] pm_addr = 8'h00;
  logic [7:0] pm_wdata = 8'h00;
  logic [7:0] op_code;
  logic op_ready, busy, exec_done, cond_branch, branch_taken, nop_equiv;
  logic [1:0] instr_len;
  logic [3:0] instr_clocks;
  logic [15:0] branch_target, clock_count;
  logic [7:0] slot = 8'h00;
  int n_checks = 0;
  int n_mismatch = 0;

  always #(`CICT_CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;

  cict_prog_mem pmem (
    .core_clk(core_clk),
    .wr_en(pm_we),
    .addr(pm_addr),
    .wr_data(pm_wdata),
    .rd_data(op_code)
  );

  cict_core DUT (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .op_valid(op_valid),
    .op_code(op_code),
    .cond_true(cond_true),
    .rel_disp(rel_disp),
    .next_pc(next_pc),
    .op_ready(op_ready),
    .busy(busy),
    .exec_done(exec_done),
    .instr_len(instr_len),
    .instr_clocks(instr_clocks),
    .cond_branch(cond_branch),
    .branch_taken(branch_taken),
    .nop_equiv(nop_equiv),
    .branch_target(branch_target),
    .clock_count(clock_count)
  );

  // ----------------------------------------------------------------
  // shared drivers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic release_reset;
    @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CICT_CHK(op_ready, 1'b0)
    @(posedge core_clk);
    @(negedge core_clk);
    `CICT_CHK(op_ready, 1'b1)
  endtask

  // op_valid rises one edge after the write so the byte is in place;
  // the condition is launched on that same rising edge
  task automatic put_op(input logic [7:0] op, input logic cond = 1'b0);
    @(posedge core_clk);
    pm_we <= 1'b1;
    pm_addr <= slot;
    pm_wdata <= op;
    slot = slot + 8'h01;
    @(posedge core_clk);
    pm_we <= 1'b0;
    op_valid <= 1'b1;
    cond_true <= cond;
  endtask

  task automatic exec_op(input logic [7:0] op, input logic cond,
                         input logic [1:0] len, input logic [3:0] clks);
    int n;
    logic [15:0] cc0;
    put_op(op, cond);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (op_ready !== 1'b1 && n < 50);
    cc0 = clock_count;
    @(posedge core_clk);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
      `CICT_CHK(busy, 1'b1)
    end while (exec_done !== 1'b1 && n < 9);
    `CICT_CHK(4'(n), clks)
    `CICT_CHK(instr_len, len)
    `CICT_CHK(instr_clocks, clks)
    @(negedge core_clk);
    `CICT_CHK(busy, 1'b0)
    `CICT_CHK(clock_count, cc0 + 16'(clks))
  endtask

  task automatic run_group(input logic [7:0] ops[$], input logic cond,
                           input logic [1:0] len, input logic [3:0] clks);
    foreach (ops[i]) begin
      exec_op(ops[i], cond, len, clks);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_arith;
    run_group('{8'h28, 8'h38, 8'h98}, 1'b0, 2'h1, 4'h1);
    run_group('{8'h26, 8'h57, 8'h46, 8'h66}, 1'b0, 2'h1, 4'h2);
    run_group('{8'h06, 8'h17}, 1'b0, 2'h1, 4'h2);
  endtask

  task automatic t_logic;
    run_group('{8'h53, 8'h43, 8'h63}, 1'b0, 2'h3, 4'h3);
    run_group('{8'h54, 8'h44, 8'h64}, 1'b0, 2'h2, 4'h2);
  endtask

  task automatic t_moves;
    exec_op(8'h85, 1'b0, 2'h3, 4'h3);
    run_group('{8'hf6, 8'hf7}, 1'b0, 2'h1, 4'h2);
    run_group('{8'h76, 8'h77}, 1'b0, 2'h2, 4'h2);
    run_group('{8'hc6, 8'hd6, 8'hd7}, 1'b0, 2'h1, 4'h2);
  endtask

  task automatic t_code_ext;
    run_group('{8'h93, 8'h83}, 1'b0, 2'h1, 4'h3);
    run_group('{8'he2, 8'hf3}, 1'b0, 2'h1, 4'h3);
    run_group('{8'he0, 8'hf0}, 1'b0, 2'h1, 4'h3);
  endtask

  task automatic t_data_pointer_16_stack_bits;
    exec_op(8'h90, 1'b0, 2'h3, 4'h3);
    exec_op(8'ha3, 1'b0, 2'h1, 4'h1);
    run_group('{8'hc0, 8'hd0}, 1'b0, 2'h2, 4'h2);
    run_group('{8'hc2, 8'hd2, 8'hb2}, 1'b0, 2'h2, 4'h2);
  endtask

  // condition held high on non-branches must not stretch them
  task automatic t_rotate;
    run_group('{8'h23, 8'h33, 8'h03, 8'h13, 8'hc4}, 1'b1, 2'h1,
              4'h1);
    `CICT_CHK(cond_branch, 1'b0)
  endtask

  task automatic t_branch;
    @(posedge core_clk);
    next_pc <= 16'hffff;
    rel_disp <= 8'h02;
    exec_op(8'h60, 1'b1, 2'h2, 4'h3);
    `CICT_CHK(branch_taken, 1'b1)
    `CICT_CHK(branch_target, 16'h0001)
    @(posedge core_clk);
    next_pc <= 16'h0005;
    rel_disp <= 8'hfb;
    exec_op(8'h60, 1'b0, 2'h2, 4'h2);
    `CICT_CHK(branch_taken, 1'b0)
    `CICT_CHK(branch_target, 16'h0000)
    exec_op(8'h20, 1'b1, 2'h3, 4'h4);
    exec_op(8'h20, 1'b0, 2'h3, 4'h3);
    `CICT_CHK(cond_branch, 1'b1)
  endtask

  // the 5-clock branch b6 and the 3-clock branch d8 both ways, and the longest op in the map
  task automatic t_more;
    exec_op(8'hb6, 1'b1, 2'h3, 4'h5);
    `CICT_CHK(branch_taken, 1'b1)
    exec_op(8'hb6, 1'b0, 2'h3, 4'h4);
    `CICT_CHK(branch_taken, 1'b0)
    exec_op(8'hd8, 1'b0, 2'h2, 4'h2);
    exec_op(8'hd8, 1'b1, 2'h2, 4'h3);
    exec_op(8'h84, 1'b0, 2'h1, 4'h8);
  endtask

  task automatic t_spare;
    exec_op(`CICT_OP_SPARE, 1'b0, 2'h1, 4'h1);
    `CICT_CHK(nop_equiv, 1'b1)
    exec_op(8'h28, 1'b0, 2'h1, 4'h1);
    `CICT_CHK(nop_equiv, 1'b0)
    exec_op(`CICT_OP_NOP, 1'b0, 2'h1, 4'h1);
    `CICT_CHK(nop_equiv, 1'b1)
  endtask

  // three single-clock ops with op_valid held: no idle cycle between
  task automatic t_back2back;
    logic [15:0] cc0;
    put_op(8'h28);
    @(negedge core_clk);
    cc0 = clock_count;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      if (i == 2) begin
        op_valid <= 1'b0;
      end
      @(negedge core_clk);
      `CICT_CHK(exec_done, 1'b1)
      `CICT_CHK(op_ready, 1'b1)
    end
    @(negedge core_clk);
    `CICT_CHK(busy, 1'b0)
    `CICT_CHK(clock_count, cc0 + 16'h0003)
  endtask

  // reset in mid-instruction must abandon it at once
  task automatic t_mid_reset;
    put_op(8'h85);
    @(posedge core_clk);
    op_valid <= 1'b0;
    @(negedge core_clk);
    `CICT_CHK(busy, 1'b1)
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(negedge core_clk);
    `CICT_CHK(busy, 1'b0)
    `CICT_CHK(exec_done, 1'b0)
    `CICT_CHK(clock_count, 16'h0000)
    release_reset;
    exec_op(8'h85, 1'b0, 2'h3, 4'h3);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    `CICT_CHK(busy, 1'b0)
    `CICT_CHK(clock_count, 16'h0000)
    release_reset;
    t_arith;
    t_logic;
    t_moves;
    t_code_ext;
    t_data_pointer_16_stack_bits;
    t_rotate;
    t_branch;
    t_more;
    t_spare;
    t_back2back;
    t_mid_reset;
    complete_run;
  end

  // about 60 ops of under 20 cycles each; generous margin
  initial begin
    #(20000 * `CICT_CLK_PERIOD_NS);
    n_mismatch++;
    complete_run;
  end
endmodule
